// >>> hdl/rail_seq_params.svh
/*
 Constants of the rail sequencer: bus offsets, field positions, reset values
 and step timing. Assumes a 40 MHz device clock.
*/
`ifndef RAIL_SEQ_PARAMS_SVH
`define RAIL_SEQ_PARAMS_SVH

`define RS_CLK_PERIOD_NS 25
`define RS_STEP_DELAY_NS 2560000
`define RS_STEP_CYCLES (`RS_STEP_DELAY_NS / `RS_CLK_PERIOD_NS)
`define RS_TIMER_W 24

`define RS_ADDR_W 8
`define RS_OFS_GATE_CFG 8'h00
`define RS_OFS_STATUS 8'h04

`define RS_GATE_PUMP_LSB 0
`define RS_GATE_CURR_LSB 2
`define RS_GATE_CFG_RESET 4'h0

`define RS_HTRANS_NONSEQ 2'h2
`define RS_HTRANS_SEQ 2'h3

`endif

// >>> hdl/rail_seq_pkg.sv
/*
 Types of the rail sequencer: step enumeration, pin flag bundle, gate
 driver setting and the AHB-Lite request carrier.
 Assumes rail_seq_params.svh holds the numeric constants.
*/
package rail_seq_pkg;

	typedef enum logic [4:0] {
		st_reset, st_wait_analog, st_wait_input, st_rail_b, st_core,
		st_rail_c, st_switch, st_monitor, st_shut_begin, st_switch_off,
		st_wait_c, st_rail_c_off, st_wait_core, st_core_off, st_wait_b,
		st_rail_b_off, st_halt
	} step_e;

	typedef struct packed {
		logic analog_ready;
		logic input_rail_ok;
		logic rail_b_ok;
		logic core_rail_ok;
		logic rail_c_ok;
		logic switched_rail_ok;
		logic shutdown_request;
	} rail_flags_s;

	typedef struct packed {
		logic [1:0] source_current;
		logic [1:0] pump_level;
	} gate_cfg_s;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_s;

endpackage

// >>> hdl/rail_sequencer_fsm.sv
/*
 Power rail sequencer: brings up rail b, the core rail, rail c and the
 switched rail in order, monitors them, and shuts down in reverse order.
 Gate driver settings and status sit behind an AHB-Lite slave.
 Assumes comparator flags and shutdown_request are asynchronous pins.
 // Function
 // [R1] wait analog ready, then input rail
 // [R2] enable rail b, hold until ok
 // [R3] core enable, 2.56 ms timeout to step 13
 // [R4] flag failed when power-up cannot finish
 // [R5] rail c enable low, wait ok
 // [R6] switch gate on, wait switched ok
 // [R7] all good asserted on monitor entry
 // [R8] any rail flag loss leaves monitoring
 // [R9] switch and all good off first
 // [R10] 2.56 ms between each rail turn-off
 // [R11] turn-off in reverse enable order
 // [R12] shutdown request jumps to step 8
 // [R13] four charge pump voltage levels stored
 // [R14] four gate source current levels stored
 // [R15] shutdown honoured only while monitoring
 // [R16] halt with outputs held until reset
 // [R17] intervals timed by reloaded clock counter
*/
`timescale 1ns/10ps
`include "rail_seq_params.svh"
module rail_sequencer_fsm #(
	parameter int STEP_CYCLES = `RS_STEP_CYCLES
) (
	input wire logic clock, // 40 MHz device clock
	input wire logic arst_n, // async reset, active low
	input wire rail_seq_pkg::rail_flags_s flags_pin, // raw comparator and request pins
	output logic rail_b_enable, // rail b converter enable, active high
	output logic core_rail_enable, // core converter enable, active high
	output logic rail_c_enable_n, // rail c converter enable, active low
	output logic switch_gate_enable, // switched rail gate drive
	output logic all_rails_good, // every rail up and monitored
	output logic sequence_failed, // power-up could not finish
	output rail_seq_pkg::gate_cfg_s gate_cfg, // charge pump and source current
	input wire rail_seq_pkg::ahb_req_s ahb_req, // AHB-Lite request
	output logic [31:0] hrdata, // AHB-Lite read data
	output logic hreadyout, // AHB-Lite ready
	output logic hresp // AHB-Lite response
);
	import rail_seq_pkg::*;

	function automatic logic timed_step(input step_e s);
		timed_step = (s == st_core) || (s == st_wait_c) || (s == st_wait_core) ||
			(s == st_wait_b);
	endfunction

	function automatic logic word_hit(input logic [31:0] addr, input logic [7:0] ofs);
		word_hit = (addr[`RS_ADDR_W-1:2] == ofs[7:2]) && (addr[31:`RS_ADDR_W] == '0);
	endfunction

	rail_flags_s sync1_reg;
	rail_flags_s flags;
	step_e state_reg;
	step_e state_next;
	logic timer_load;
	logic timer_expired;
	logic rails_all_ok;

	// two flops per pin; only the second stage is read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			flags <= '0;
		end else begin
			sync1_reg <= flags_pin;
			flags <= sync1_reg;
		end
	end

	assign rails_all_ok = flags.input_rail_ok && flags.rail_b_ok && flags.rail_c_ok &&
		flags.core_rail_ok && flags.switched_rail_ok;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_reset: state_next = st_wait_analog;
			st_wait_analog: if (flags.analog_ready) state_next = st_wait_input; // [R1]
			st_wait_input: if (flags.input_rail_ok) state_next = st_rail_b; // [R1]
			st_rail_b: if (flags.rail_b_ok) state_next = st_core; // [R2]
			st_core: begin
				if (flags.core_rail_ok) begin
					state_next = st_rail_c;
				end else if (timer_expired) begin
					state_next = st_core_off; // [R3]
				end
			end
			st_rail_c: if (flags.rail_c_ok) state_next = st_switch; // [R5]
			st_switch: if (flags.switched_rail_ok) state_next = st_monitor; // [R6]
			st_monitor: begin
				// only interruptible step, so the request is looked at here alone
				if (!rails_all_ok || flags.shutdown_request) begin
					state_next = st_shut_begin; // [R8] [R12] [R15]
				end
			end
			st_shut_begin: state_next = st_switch_off;
			st_switch_off: state_next = st_wait_c;
			st_wait_c: if (timer_expired) state_next = st_rail_c_off; // [R10]
			st_rail_c_off: state_next = st_wait_core;
			st_wait_core: if (timer_expired) state_next = st_core_off; // [R10]
			st_core_off: state_next = st_wait_b;
			st_wait_b: if (timer_expired) state_next = st_rail_b_off; // [R10]
			st_rail_b_off: state_next = st_halt;
			st_halt: state_next = st_halt; // [R16]
			default: state_next = st_halt;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= st_reset;
		end else begin
			state_reg <= state_next;
		end
	end

	// reload on entry of every timed step
	assign timer_load = (state_next != state_reg) && timed_step(state_next); // [R17]

	rail_step_timer #(
		.WIDTH(`RS_TIMER_W),
		.CYCLES(STEP_CYCLES)
	) u_step_timer (
		.clock(clock),
		.arst_n(arst_n),
		.load(timer_load),
		.expired(timer_expired)
	);

	// outputs change on the edge that enters the step
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rail_b_enable <= 1'b0;
		end else if (state_next != state_reg) begin
			if (state_next == st_rail_b) begin
				rail_b_enable <= 1'b1; // [R2]
			end else if (state_next == st_rail_b_off) begin
				rail_b_enable <= 1'b0; // [R10] [R11]
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			core_rail_enable <= 1'b0;
		end else if (state_next != state_reg) begin
			if (state_next == st_core) begin
				core_rail_enable <= 1'b1; // [R3]
			end else if (state_next == st_core_off) begin
				core_rail_enable <= 1'b0; // [R10] [R11]
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rail_c_enable_n <= 1'b1;
		end else if (state_next != state_reg) begin
			if (state_next == st_rail_c) begin
				rail_c_enable_n <= 1'b0; // [R5]
			end else if (state_next == st_rail_c_off) begin
				rail_c_enable_n <= 1'b1; // [R10] [R11]
			end
		end
	end

	// switch and all good drop together, ahead of any converter
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			switch_gate_enable <= 1'b0;
			all_rails_good <= 1'b0;
		end else if (state_next != state_reg) begin
			if (state_next == st_switch) begin
				switch_gate_enable <= 1'b1; // [R6]
			end else if (state_next == st_monitor) begin
				all_rails_good <= 1'b1; // [R7]
			end else if (state_next == st_switch_off) begin
				switch_gate_enable <= 1'b0; // [R9]
				all_rails_good <= 1'b0; // [R9]
			end
		end
	end

	// sticky until device reset; the halt step never clears it
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sequence_failed <= 1'b0;
		end else if (state_reg == st_core && state_next == st_core_off) begin
			sequence_failed <= 1'b1; // [R3] [R4]
		end
	end

	// AHB-Lite slave, zero wait states
	logic access_ok;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic [31:0] status_word;

	assign access_ok = ahb_req.hsel && ahb_req.hready &&
		(ahb_req.htrans == `RS_HTRANS_NONSEQ || ahb_req.htrans == `RS_HTRANS_SEQ);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign status_word = {11'h000, flags, all_rails_good, sequence_failed,
		switch_gate_enable, rail_c_enable_n, core_rail_enable, rail_b_enable,
		3'h0, 5'(state_reg)};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= access_ok && ahb_req.hwrite;
			if (access_ok) begin
				wr_addr_reg <= ahb_req.haddr;
			end
		end
	end

	// gate setting is written at the end of the data phase and drives gate_cfg at once
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gate_cfg <= `RS_GATE_CFG_RESET;
		end else if (wr_pend_reg && word_hit(wr_addr_reg, `RS_OFS_GATE_CFG)) begin
			gate_cfg.pump_level <= ahb_req.hwdata[`RS_GATE_PUMP_LSB +: 2]; // [R13]
			gate_cfg.source_current <= ahb_req.hwdata[`RS_GATE_CURR_LSB +: 2]; // [R14]
		end
	end

	// read data latched in the address phase; unmapped reads return zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h00000000;
		end else if (access_ok && !ahb_req.hwrite) begin
			if (word_hit(ahb_req.haddr, `RS_OFS_GATE_CFG)) begin
				hrdata <= {28'h0000000, gate_cfg};
			end else if (word_hit(ahb_req.haddr, `RS_OFS_STATUS)) begin
				hrdata <= status_word;
			end else begin
				hrdata <= 32'h00000000;
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_idle_outputs: assert property ( // [R1]
		(state_reg inside {st_reset, st_wait_analog, st_wait_input}) |->
		(!rail_b_enable && !core_rail_enable && rail_c_enable_n &&
		!switch_gate_enable && !all_rails_good))
		else $error("rail enabled before input rail is ready");

	a_rail_b_hold: assert property ( // [R2]
		(state_reg == st_rail_b && !flags.rail_b_ok) |=>
		(state_reg == st_rail_b && rail_b_enable && !core_rail_enable))
		else $error("rail b step left without its ok flag");

	a_core_timeout: assert property ( // [R3]
		(state_reg == st_core && timer_expired && !flags.core_rail_ok) |=>
		(state_reg == st_core_off && sequence_failed) ##1 !core_rail_enable)
		else $error("core timeout did not fail and jump");

	a_core_wait_len: assert property ( // [R3]
		(state_reg == st_rail_b && flags.rail_b_ok) ##1
		(!flags.core_rail_ok) [*8] |-> (state_reg == st_core && !sequence_failed))
		else $error("core step left early");

	a_failed_sticky: assert property ( // [R4]
		sequence_failed |=> (sequence_failed && state_reg != st_monitor))
		else $error("failed flag cleared or monitoring reached");

	a_rail_c_low: assert property ( // [R5]
		(state_reg == st_rail_c) |-> (!rail_c_enable_n && core_rail_enable && rail_b_enable))
		else $error("rail c enable not active low in its step");

	a_switch_on: assert property ( // [R6]
		(state_reg == st_switch && !flags.switched_rail_ok) |=>
		(switch_gate_enable && state_reg == st_switch && !all_rails_good))
		else $error("switch step misbehaves");

	a_good_entry: assert property ( // [R7]
		(state_reg == st_switch && flags.switched_rail_ok) |=>
		(state_reg == st_monitor && all_rails_good))
		else $error("all good late on monitor entry");

	a_monitor_exit: assert property ( // [R8]
		(state_reg == st_monitor && !rails_all_ok) |=> (state_reg == st_shut_begin))
		else $error("rail loss not acted on");

	a_switch_first: assert property ( // [R9]
		$fell(switch_gate_enable) |-> (!all_rails_good && rail_b_enable &&
		core_rail_enable && !rail_c_enable_n))
		else $error("switch not first off");

	a_off_spacing: assert property ( // [R10]
		(state_reg inside {st_wait_c, st_wait_core, st_wait_b} && !timer_expired) |=>
		$stable(state_reg) && $stable(rail_c_enable_n) && $stable(core_rail_enable))
		else $error("turn-off step left before interval ended");

	a_reverse_order: assert property ( // [R11]
		$fell(core_rail_enable) |-> (rail_c_enable_n && !switch_gate_enable))
		else $error("core turned off out of order");

	a_rail_b_last: assert property ( // [R11]
		$fell(rail_b_enable) |-> (!core_rail_enable && rail_c_enable_n))
		else $error("rail b turned off out of order");

	a_shutdown_jump: assert property ( // [R12]
		(state_reg == st_monitor && rails_all_ok && flags.shutdown_request) |=>
		(state_reg == st_shut_begin && all_rails_good && switch_gate_enable)
		##1 (state_reg == st_switch_off && !all_rails_good))
		else $error("shutdown request not handled");

	a_request_ignored: assert property ( // [R15]
		(state_reg inside {st_wait_analog, st_wait_input, st_rail_b, st_core, st_rail_c,
		st_switch} && flags.shutdown_request) |=>
		!(state_reg inside {st_shut_begin, st_switch_off}))
		else $error("shutdown honoured outside monitoring");

	a_halt_hold: assert property ( // [R16]
		(state_reg == st_halt) |=> (state_reg == st_halt && $stable(rail_b_enable) &&
		$stable(sequence_failed) && !rail_b_enable && !core_rail_enable))
		else $error("halt step did not hold");

	a_timer_reload: assert property ( // [R17]
		timer_load |=> !timer_expired)
		else $error("timer expired right after reload");

	a_failed_cause: assert property ( // [R4]
		$rose(sequence_failed) |-> (state_reg == st_core_off && $past(state_reg) == st_core))
		else $error("failed flag raised outside core timeout");

	a_early_steps: assert property ( // [R5]
		(state_reg inside {st_rail_b, st_core}) |-> (rail_c_enable_n && !switch_gate_enable))
		else $error("rail c or switch on too early");

	a_good_window: assert property ( // [R7]
		all_rails_good |-> (state_reg inside {st_monitor, st_shut_begin}))
		else $error("all good outside monitoring");

	a_rail_c_first: assert property ( // [R11]
		$rose(rail_c_enable_n) |-> (!switch_gate_enable && core_rail_enable && rail_b_enable))
		else $error("rail c turned off out of order");

	a_gate_hold: assert property ( // [R13] [R14]
		!(wr_pend_reg && word_hit(wr_addr_reg, `RS_OFS_GATE_CFG)) |=> $stable(gate_cfg))
		else $error("gate setting changed without a write");

endmodule

// >>> hdl/rail_step_timer.sv
/*
 Step interval timer: reloads on load, then counts device clocks down.
 Assumes load is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/10ps
module rail_step_timer #(
	parameter int WIDTH = 24,
	parameter int CYCLES = 102400
) (
	input wire logic clock, // device clock
	input wire logic arst_n, // async reset, active low
	input wire logic load, // restart the interval
	output logic expired // interval over, level until next load
);

	logic [WIDTH-1:0] count_reg;
	logic running_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
			running_reg <= 1'b0;
		end else if (load) begin
			count_reg <= WIDTH'(CYCLES - 1);
			running_reg <= 1'b1;
		end else if (running_reg && count_reg != '0) begin
			count_reg <= count_reg - WIDTH'(1);
		end
	end

	assign expired = running_reg && (count_reg == '0);

endmodule

// >>> testbench/rail_partner.sv
/*
 Far-side model: rail b, core and rail c converters plus the switched rail,
 each with its in-range comparator. Assumes enables arrive as active-high bits.
*/
`timescale 1ns/10ps
module rail_partner (
	input wire logic clock, // device clock
	input wire logic arst_n, // async reset, active low
	input wire logic [3:0] en, // b, core, c, switch; active high
	input wire logic [3:0] kill, // hold a comparator low
	input wire logic [7:0] rise_delay, // cycles from enable to in range
	output logic [3:0] ok // in-range flags
);
	int cnt_reg [4];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '{default: 0};
			ok <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				// rail discharges at once, so a dropped enable drops its flag
				cnt_reg[i] <= en[i] ? cnt_reg[i] + 1 : 0;
				ok[i] <= en[i] && (cnt_reg[i] >= int'(rise_delay)) && !kill[i];
			end
		end
	end
endmodule

// >>> testbench/rail_sequencer_fsm_tb.sv
/*
 Self-checking bench for the rail sequencer: a queue of expected output
 vectors is matched at every output change. Assumes STEP_CYCLES is shortened.
*/
`timescale 1ns/10ps
`include "rail_seq_params.svh"
module rail_sequencer_fsm_tb;
	import rail_seq_pkg::*;
	localparam int S = 16;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic analog = 1'b0;
	logic inp = 1'b0;
	logic sd = 1'b0;
	logic [3:0] kill = 4'h0;
	logic [3:0] ok;
	logic [7:0] rise = 8'h01;
	rail_flags_s flags;
	ahb_req_s bus = '0;
	ahb_req_s req;
	logic rail_b_enable, core_rail_enable, rail_c_enable_n, switch_gate_enable;
	logic all_rails_good, sequence_failed, hreadyout, hresp;
	logic [31:0] hrdata, rd, d;
	gate_cfg_s gate_cfg;
	logic [5:0] o, last;
	logic [5:0] exp_q [$];
	int gap_q [$];
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int last_cyc = 0;

	assign o = {rail_b_enable, core_rail_enable, rail_c_enable_n, switch_gate_enable,
		all_rails_good, sequence_failed};
	assign flags = '{analog, inp, ok[3], ok[2], ok[1], ok[0], sd};
	always_comb begin
		req = bus;
		req.hready = hreadyout;
	end

	rail_sequencer_fsm #(.STEP_CYCLES(S)) u_rail_sequencer_fsm (.clock(clock), .arst_n(arst_n),
		.flags_pin(flags), .rail_b_enable(rail_b_enable), .core_rail_enable(core_rail_enable),
		.rail_c_enable_n(rail_c_enable_n), .switch_gate_enable(switch_gate_enable),
		.all_rails_good(all_rails_good), .sequence_failed(sequence_failed),
		.gate_cfg(gate_cfg), .ahb_req(req), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp));
	rail_partner u_rail_partner (.clock(clock), .arst_n(arst_n),
		.en({rail_b_enable, core_rail_enable, ~rail_c_enable_n, switch_gate_enable}),
		.kill(kill), .rise_delay(rise), .ok(ok));

	initial begin
		forever #12.5 clock = ~clock;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		comparisons++;
		if (seen !== expv) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, expv, seen);
		end
	endtask

	task results;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task push(input logic [5:0] v, input int g);
		exp_q.push_back(v);
		gap_q.push_back(g);
	endtask

	task bus_cycle(input logic [31:0] a, input logic w, input logic [31:0] wd);
		int waits;
		waits = 0;
		@(posedge clock);
		bus.hsel <= 1'b1;
		bus.haddr <= a;
		bus.htrans <= `RS_HTRANS_NONSEQ;
		bus.hwrite <= w;
		bus.hsize <= 3'h2;
		do begin
			@(posedge clock);
			waits++;
		end while (hreadyout !== 1'b1);
		bus.hsel <= 1'b0;
		bus.htrans <= 2'h0;
		bus.hwdata <= wd;
		do begin
			@(posedge clock);
			waits++;
		end while (hreadyout !== 1'b1);
		rd = hrdata;
		check("hresp", hresp, 0);
		// slave promises zero wait states: one edge per phase
		check("bus edges", waits, 2);
	endtask

	task reset_dut;
		arst_n <= 1'b0;
		analog <= 1'b0;
		inp <= 1'b0;
		sd <= 1'b0;
		kill <= 4'h0;
		rise <= 8'(1 + $urandom % 8);
		repeat (8) @(posedge clock);
		check("reset outputs", o, 6'b001000);
		check("reset gate_cfg", gate_cfg, 0);
		exp_q.delete();
		gap_q.delete();
		last = 6'b001000;
		arst_n <= 1'b1;
	endtask

	// each output change must be the next one queued, at the queued spacing
	always @(negedge clock) begin
		if (arst_n === 1'b1 && o !== last) begin
			if (exp_q.size() == 0) begin
				check("unexpected change", o, last);
			end else begin
				check("outputs", o, exp_q[0]);
				if (gap_q[0] > 0)
					check("step spacing", 32'(cyc - last_cyc), 32'(gap_q[0]));
				void'(exp_q.pop_front());
				void'(gap_q.pop_front());
			end
			last = o;
			last_cyc = cyc;
		end
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			results;
		end
	end

	initial begin
		void'($urandom(80));
		reset_dut;
		for (int i = 0; i < 16; i++) begin
			d = ($urandom & 32'hFFFF_FFF0) | 32'(i);
			bus_cycle(`RS_OFS_GATE_CFG, 1'b1, d);
			@(negedge clock);
			check("gate_cfg", gate_cfg, 32'(i));
			bus_cycle(`RS_OFS_GATE_CFG, 1'b0, 32'h0);
			check("gate_cfg read", rd, 32'(i));
		end
		bus_cycle(32'h10, 1'b1, 32'h3);
		bus_cycle(`RS_OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
		bus_cycle(32'h10, 1'b0, 32'h0);
		check("unmapped read", rd, 0);
		bus_cycle(32'h104, 1'b0, 32'h0);
		check("alias read", rd, 0);
		bus_cycle(`RS_OFS_GATE_CFG, 1'b0, 32'h0);
		check("gate_cfg kept", rd, 32'hF);
		// runs 0..4 drop one rail flag, 5 requests shutdown, 6 starves the core rail
		for (int k = 0; k < 7; k++) begin
			reset_dut;
			if (k == 6)
				kill <= 4'b0100;
			push(6'b101000, 0);
			push(6'b111000, 0);
			if (k == 6) begin
				push(6'b101001, S);
				push(6'b001001, S + 1);
			end else begin
				push(6'b110000, 0);
				push(6'b110100, 0);
				push(6'b110110, 0);
			end
			repeat (5) @(posedge clock);
			// input rail and a stray request must not start anything yet
			inp <= 1'b1;
			sd <= 1'b1;
			repeat (6) @(posedge clock);
			sd <= 1'b0;
			repeat (4) @(posedge clock);
			bus_cycle(`RS_OFS_STATUS, 1'b0, 32'h0);
			check("step", rd[4:0], 1);
			inp <= 1'b0;
			analog <= 1'b1;
			repeat (8) @(posedge clock);
			bus_cycle(`RS_OFS_STATUS, 1'b0, 32'h0);
			check("step", rd[4:0], 2);
			inp <= 1'b1;
			for (int n = 0; n < 200 && all_rails_good !== 1'b1; n++)
				@(posedge clock);
			if (k < 6) begin
				bus_cycle(`RS_OFS_STATUS, 1'b0, 32'h0);
				check("status", rd, 32'h001F_AB07);
				push(6'b110000, 0);
				push(6'b111000, S + 1);
				push(6'b101000, S + 1);
				push(6'b001000, S + 1);
				if (k == 0)
					inp <= 1'b0;
				else if (k == 5)
					sd <= 1'b1;
				else
					kill <= 4'b1000 >> (k - 1);
			end
			repeat (4 * S + 40) @(posedge clock);
			check("pending steps", 32'(exp_q.size()), 0);
			analog <= 1'b0;
			inp <= 1'b0;
			sd <= 1'b1;
			repeat (20) @(posedge clock);
			bus_cycle(`RS_OFS_STATUS, 1'b0, 32'h0);
			check("halt status", rd[13:0], (k == 6) ? 14'h1410 : 14'h0410);
		end
		results;
	end
endmodule
